/* hdl/free_run_timer_pkg.sv */
// Constants shared by the free-running and interval timer block.
package free_run_timer_pkg;

    // Register word indices; the byte address on the bus is four times the index.
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_FR_LOW = 8'h20;
    localparam logic [7:0] IDX_FR_HIGH = 8'h21;
    localparam logic [7:0] IDX_IV_LOW = 8'h26;
    localparam logic [7:0] IDX_IV_HIGH = 8'h27;
    localparam logic [7:0] IDX_RL_LOW = 8'h28;
    localparam logic [7:0] IDX_RL_HIGH = 8'h29;
    localparam logic [7:0] IDX_POSTED = 8'h30;
    localparam logic [7:0] IDX_CONTROL = 8'h31;

    // Counter widths.
    localparam int FR_W = 16;
    localparam int IV_W = 12;
    localparam int IV_HI_W = IV_W - 8;

    // Posted interrupt bit positions in posted_interrupt_clear.
    localparam int POST_TICK = 0;
    localparam int POST_WRAP = 1;
    localparam int POST_IVL = 2;
    localparam int POST_N = 3;

    // Control register fields.
    localparam int CTRL_FR_EN = 0;
    localparam int CTRL_IV_EN = 1;
    localparam int CTRL_W = 2;
    localparam int STAT_TCLK = 7;

    // Reset values.
    localparam logic [15:0] FR_RESET = 16'h0000;
    localparam logic [11:0] IV_RESET = 12'h000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [2:0] POST_RESET = 3'h0;

    // Timer source and tick period; the tick falls every TICK_COUNTS timer edges.
    localparam int TIMER_CLK_KHZ = 4000;
    localparam int TICK_PERIOD_US = 1024;
    localparam int TICK_COUNTS = TICK_PERIOD_US * TIMER_CLK_KHZ / 1000;
    localparam int TICK_BITS = $clog2(TICK_COUNTS);

    // Pin synchroniser depth for the timer source.
    localparam int SYNC_STAGES = 3;

endpackage

/* hdl/free_run_and_interval_timer.sv */
// Free-running 16-bit timer and 12-bit interval timer with a classic Wishbone slave.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module free_run_and_interval_timer (
    input wire logic sys_clk, // System clock, 50 MHz.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic [9:0] wb_adr_i, // Wishbone byte address.
    input wire logic [31:0] wb_dat_i, // Wishbone write data.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    output logic wb_ack_o, // Wishbone acknowledge.
    input wire logic timerClk, // Asynchronous 4/6 MHz timer source pin.
    input wire logic [free_run_timer_pkg::POST_N-1:0] irqTaken, // Interrupt taken pulses.
    output logic tickIrq, // Posted 1024 us tick interrupt.
    output logic wrapIrq, // Posted free-running wrap interrupt.
    output logic intervalIrq // Posted interval timer interrupt.
);
    import free_run_timer_pkg::*;

    // Timer source synchroniser and its filtered level.
    logic [SYNC_STAGES-1:0] tclkSync_r;
    logic tclkLevel_r;
    logic tclkAgree;
    logic timerRise;
    logic tclkNew;

    // Bus side.
    logic ack_r;
    logic [31:0] datOut_r;
    logic take;
    logic writeLow;
    logic [IDX_W-1:0] wordIdx;
    logic [7:0] wrByte;
    logic [7:0] readByte;
    logic readTake;

    // Register decodes.
    logic rdFrLow;
    logic rdIvLow;
    logic wrFrLow;
    logic wrFrHigh;
    logic wrRlLow;
    logic wrRlHigh;
    logic wrPosted;
    logic wrControl;

    // Read selection.
    logic atFrLow;
    logic atFrHigh;
    logic atIvLow;
    logic atIvHigh;
    logic atRlLow;
    logic atRlHigh;
    logic atPosted;
    logic atControl;
    logic [7:0] ivHoldByte;
    logic [7:0] reloadHighByte;
    logic [7:0] postedByte;
    logic [7:0] controlByte;

    // Free-running counter state.
    logic [FR_W-1:0] frCount_r;
    logic [FR_W-1:0] frCount_nxt;
    logic [7:0] frHold_r;
    logic [7:0] frWrLow_r;
    logic frEn;
    logic frStep;
    logic tickEvent;
    logic wrapEvent;
    logic [FR_W-1:0] frLoad;
    logic tickCarry;
    logic wrapCarry;

    // Interval timer state.
    logic [IV_W-1:0] ivCount_r;
    logic [IV_W-1:0] ivCount_nxt;
    logic [IV_HI_W-1:0] ivHold_r;
    logic [IV_W-1:0] reload_r;
    logic [7:0] rlLowStage_r;
    logic ivEn;
    logic ivStep;
    logic ivTerminal;
    logic ivAtZero;

    // Control and posted events.
    logic [CTRL_W-1:0] ctrl_r;
    logic [POST_N-1:0] posted_r;
    logic [POST_N-1:0] postSet;
    logic [POST_N-1:0] postClr;
    logic [POST_N-1:0] wrClr;

    // True when the current request is taken and addresses the given register.
    function automatic logic regHit(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] at,
                                    input logic req);
        regHit = req && (at == idx);
    endfunction

    // timer source crossing
    // The pin passes three flops; the level moves only when the last two agree,
    // so a glitch shorter than one system clock never counts as a timer edge.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tclkSync_r <= '0;
        end else begin
            tclkSync_r <= {tclkSync_r[SYNC_STAGES-2:0], timerClk};
        end
    end

    assign tclkNew = tclkSync_r[SYNC_STAGES-1];
    assign tclkAgree = (tclkNew == tclkSync_r[SYNC_STAGES-2]);
    // Each source level must last two system clocks to be seen, which bounds the
    // source at a quarter of the system rate; faster edges merge and are lost.
    assign timerRise = tclkAgree && tclkNew && !tclkLevel_r;

    // The level clears to the idle low of the pin, so leaving reset makes no false edge.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tclkLevel_r <= 1'b0;
        end else if (tclkAgree) begin
            tclkLevel_r <= tclkSync_r[SYNC_STAGES-1];
        end
    end

    // Bus decode. A request is taken once; the acknowledge then blocks a second
    // take of the same request, so read side effects happen exactly once.
    assign take = wb_cyc_i && wb_stb_i && !ack_r;
    // Address bits 1:0 are ignored; each register sits in a word of its own.
    assign wordIdx = wb_adr_i[IDX_W+1:2];
    // Only byte lane 0 carries data; a write without it is acknowledged and ignored.
    assign wrByte = wb_dat_i[7:0];
    assign writeLow = take && wb_we_i && wb_sel_i[0];
    assign readTake = take && !wb_we_i;

    assign rdFrLow = regHit(IDX_FR_LOW, wordIdx, readTake);
    assign rdIvLow = regHit(IDX_IV_LOW, wordIdx, readTake);
    assign wrFrLow = regHit(IDX_FR_LOW, wordIdx, writeLow);
    assign wrFrHigh = regHit(IDX_FR_HIGH, wordIdx, writeLow);
    assign wrRlLow = regHit(IDX_RL_LOW, wordIdx, writeLow);
    assign wrRlHigh = regHit(IDX_RL_HIGH, wordIdx, writeLow);
    assign wrPosted = regHit(IDX_POSTED, wordIdx, writeLow);
    assign wrControl = regHit(IDX_CONTROL, wordIdx, writeLow);

    // Read selection. Every source is an operand of the assignment itself, so the
    // selected byte follows the counters while the address stands still.
    assign atFrLow = (wordIdx == IDX_FR_LOW);
    assign atFrHigh = (wordIdx == IDX_FR_HIGH);
    assign atIvLow = (wordIdx == IDX_IV_LOW);
    assign atIvHigh = (wordIdx == IDX_IV_HIGH);
    assign atRlLow = (wordIdx == IDX_RL_LOW);
    assign atRlHigh = (wordIdx == IDX_RL_HIGH);
    assign atPosted = (wordIdx == IDX_POSTED);
    assign atControl = (wordIdx == IDX_CONTROL);

    // Reserved bits and unmapped words read as zero.
    assign ivHoldByte = {{(8 - IV_HI_W){1'b0}}, ivHold_r};
    assign reloadHighByte = {{(8 - IV_HI_W){1'b0}}, reload_r[IV_W-1:8]};
    assign postedByte = {{(8 - POST_N){1'b0}}, posted_r};
    assign controlByte = {tclkLevel_r, {(7 - CTRL_W){1'b0}}, ctrl_r};
    assign readByte = atFrLow ? frCount_r[7:0] :
                      atFrHigh ? frHold_r :
                      atIvLow ? ivCount_r[7:0] :
                      atIvHigh ? ivHoldByte :
                      atRlLow ? rlLowStage_r :
                      atRlHigh ? reloadHighByte :
                      atPosted ? postedByte :
                      (atControl ? controlByte : BYTE_RESET);

    // The acknowledge comes from a flop, so every access is answered one cycle
    // after its take and ack never loops back into the master's strobe logic.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take;
        end
    end

    // Read data stands from the acknowledge until the next take; writes return zero.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            datOut_r <= 32'h0;
        end else if (take) begin
            datOut_r <= wb_we_i ? 32'h0 : {24'h0, readByte};
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = datOut_r;

    // Both timers run from reset. Clearing an enable freezes that counter with its
    // value kept; bit 7 still shows the synchronised source level for diagnosis.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_r <= CTRL_RESET;
        end else if (wrControl) begin
            ctrl_r <= wrByte[CTRL_W-1:0];
        end
    end

    assign frEn = ctrl_r[CTRL_FR_EN];
    assign ivEn = ctrl_r[CTRL_IV_EN];

    // free-running count
    // A software load wins over a timer edge in the same cycle; that edge is lost.
    assign frStep = frEn && timerRise && !wrFrHigh;
    assign frLoad = {wrByte, frWrLow_r};
    assign frCount_nxt = wrFrHigh ? frLoad :
                         (frStep ? frCount_r + FR_W'(1) : frCount_r);

    // Both periods assume the 4 MHz source; a 6 MHz source shortens them in
    // proportion, which software must allow for.
    assign tickCarry = (frCount_r[TICK_BITS-1:0] == {TICK_BITS{1'b1}});
    assign wrapCarry = (frCount_r == {FR_W{1'b1}});
    assign tickEvent = frStep && tickCarry;
    assign wrapEvent = frStep && wrapCarry;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            frCount_r <= FR_RESET;
        end else begin
            frCount_r <= frCount_nxt;
        end
    end

    // Writing the high byte alone loads it over whatever low byte was staged last.
    // low byte staging
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            frWrLow_r <= BYTE_RESET;
        end else if (wrFrLow) begin
            frWrLow_r <= wrByte;
        end
    end

    // A high read with no low read before it returns the byte captured last time.
    // capture high byte
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            frHold_r <= BYTE_RESET;
        end else if (rdFrLow) begin
            frHold_r <= frCount_r[15:8];
        end
    end

    // reload staging
    // The low byte waits in a stage and both halves take effect with the nibble,
    // so the interval timer never reloads from a half-written value.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rlLowStage_r <= BYTE_RESET;
        end else if (wrRlLow) begin
            rlLowStage_r <= wrByte;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reload_r <= IV_RESET;
        end else if (wrRlHigh) begin
            reload_r <= {wrByte[IV_HI_W-1:0], rlLowStage_r};
        end
    end

    // count down and reload
    // The period is reload plus one timer edges; a reload of zero fires on every edge.
    // A new reload is used at the next terminal count; the running count is left alone.
    assign ivStep = ivEn && timerRise;
    assign ivAtZero = (ivCount_r == IV_RESET);
    assign ivTerminal = ivStep && ivAtZero;
    assign ivCount_nxt = ivTerminal ? reload_r :
                         (ivStep ? ivCount_r - IV_W'(1) : ivCount_r);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ivCount_r <= IV_RESET;
        end else begin
            ivCount_r <= ivCount_nxt;
        end
    end

    // The nibble is captured with the low read so a borrow between reads cannot tear it.
    // latch upper nibble
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ivHold_r <= '0;
        end else if (rdIvLow) begin
            ivHold_r <= ivCount_r[IV_W-1:8];
        end
    end

    assign postSet[POST_TICK] = tickEvent;
    assign postSet[POST_WRAP] = wrapEvent;
    assign postSet[POST_IVL] = ivTerminal;

    // sticky posted bits
    // Writing a one leaves a bit alone, and a new event beats a clear in the same cycle.
    assign wrClr = wrPosted ? ~wrByte[POST_N-1:0] : '0;
    genvar gi;
    generate
        for (gi = 0; gi < POST_N; gi++) begin : g_post
            assign postClr[gi] = wrClr[gi] || irqTaken[gi];
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    posted_r[gi] <= POST_RESET[gi];
                end else begin
                    posted_r[gi] <= postSet[gi] || (posted_r[gi] && !postClr[gi]);
                end
            end
        end
    endgenerate

    // Posted bits drive the interrupt lines directly; masking lives outside this block.
    assign tickIrq = posted_r[POST_TICK];
    assign wrapIrq = posted_r[POST_WRAP];
    assign intervalIrq = posted_r[POST_IVL];

endmodule

`default_nettype wire

/* sim/free_run_and_interval_timer_props.sv */
// Concurrent checks on bus timing and posted interrupt behaviour of the timer block.
`timescale 1ns/10ps
`default_nettype none
module free_run_and_interval_timer_props (
    input wire logic sys_clk, // Clock.
    input wire logic reset_n, // Reset.
    input wire logic [9:0] wb_adr_i, // Address.
    input wire logic [31:0] wb_dat_i, // Write data.
    input wire logic [31:0] wb_dat_o, // Read data.
    input wire logic wb_we_i, // Write.
    input wire logic [3:0] wb_sel_i, // Selects.
    input wire logic wb_cyc_i, // Cycle.
    input wire logic wb_stb_i, // Strobe.
    input wire logic wb_ack_o, // Ack.
    input wire logic timerClk, // Timer pin.
    input wire logic [free_run_timer_pkg::POST_N-1:0] irqTaken, // Taken.
    input wire logic tickIrq, // Tick.
    input wire logic wrapIrq, // Wrap.
    input wire logic intervalIrq // Interval.
);
    import free_run_timer_pkg::*;
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic [7:0] idx = wb_adr_i[9:2];
    wire logic rd = take && !wb_we_i;
    // A written zero clears a posted bit, a written one leaves it alone.
    wire logic [2:0] clr = (take && wb_we_i && wb_sel_i[0] && idx == IDX_POSTED) ?
        ~wb_dat_i[2:0] : 3'h0;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_ack_follows: assert property (take |=> wb_ack_o)
        else $error("Ack missing after a request.");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack longer than one cycle.");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
        else $error("Ack without a request.");
    a_data_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("Upper read data not zero.");
    a_nibble_zero: assert property ((rd && (idx == IDX_IV_HIGH || idx == IDX_RL_HIGH))
        |=> wb_dat_o[7:4] == 4'h0) else $error("High nibble register bits 7:4 not zero.");
    a_unmapped_zero: assert property ((rd && idx > IDX_CONTROL) |=> wb_dat_o == 32'h0)
        else $error("Unmapped read not zero.");
    a_tick_sticky: assert property ((tickIrq && !irqTaken[0] && !clr[0]) |=> tickIrq)
        else $error("Tick dropped without a clear.");
    a_wrap_sticky: assert property ((wrapIrq && !irqTaken[1] && !clr[1]) |=> wrapIrq)
        else $error("Wrap dropped without a clear.");
    a_ivl_sticky: assert property ((intervalIrq && !irqTaken[2] && !clr[2])
        |=> intervalIrq) else $error("Interval dropped without a clear.");
endmodule
bind free_run_and_interval_timer free_run_and_interval_timer_props
    i_free_run_and_interval_timer_props (.sys_clk, .reset_n, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .timerClk, .irqTaken, .tickIrq,
    .wrapIrq, .intervalIrq);
`default_nettype wire

/* sim/test_free_run_and_interval_timer.sv */
// Self-checking bench for the free-running and interval timer block.
`timescale 1ns/10ps
`default_nettype none
module test_free_run_and_interval_timer;
    import free_run_timer_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_ack_o;
    logic timerClk = 1'b0;
    logic [POST_N-1:0] irqTaken = 3'h0;
    logic tickIrq;
    logic wrapIrq;
    logic intervalIrq;
    logic tEn = 1'b0;
    logic [1:0] div = 2'h0;
    logic [7:0] q;
    logic [7:0] regs [7] = '{IDX_FR_LOW, IDX_FR_HIGH, IDX_IV_LOW, IDX_IV_HIGH, IDX_RL_LOW,
        IDX_RL_HIGH, IDX_POSTED};
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    always #10 sys_clk = ~sys_clk;
    free_run_and_interval_timer i_free_run_and_interval_timer (.sys_clk, .reset_n, .wb_adr_i,
        .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .timerClk,
        .irqTaken, .tickIrq, .wrapIrq, .intervalIrq);
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // The timer source runs at a quarter of the system rate and stands still when stopped.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (tEn) begin
            div <= div + 2'h1;
            if (div[0]) timerClk <= ~timerClk;
        end
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= 4'h1;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(q, exp);
    endtask
    task automatic run(input int n);
        tEn <= 1'b1;
        repeat (n) @(posedge sys_clk);
        tEn <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        foreach (regs[i]) rd(regs[i], BYTE_RESET);
        rd(IDX_CONTROL, 8'h03);
        rd(8'h3f, 8'h00);
        bus(1'b1, IDX_IV_LOW, 8'haa);
        rd(IDX_IV_LOW, 8'h00);
        $display("Reset values test done");
        bus(1'b1, IDX_FR_LOW, 8'h34);
        rd(IDX_FR_LOW, 8'h00);
        bus(1'b1, IDX_FR_HIGH, 8'h12);
        rd(IDX_FR_LOW, 8'h34);
        rd(IDX_FR_HIGH, 8'h12);
        bus(1'b1, IDX_FR_HIGH, 8'h56);
        rd(IDX_FR_LOW, 8'h34);
        rd(IDX_FR_HIGH, 8'h56);
        bus(1'b1, IDX_FR_LOW, 8'hfe);
        bus(1'b1, IDX_FR_HIGH, 8'h20);
        rd(IDX_FR_LOW, 8'hfe);
        run(40);
        rd(IDX_FR_HIGH, 8'h20);
        bus(1'b0, IDX_FR_LOW, 8'h00);
        rd(IDX_FR_HIGH, 8'h21);
        $display("Free-running access test done");
        bus(1'b1, IDX_RL_LOW, 8'hff);
        rd(IDX_RL_HIGH, 8'h00);
        bus(1'b1, IDX_RL_HIGH, 8'hf1);
        rd(IDX_RL_HIGH, 8'h01);
        rd(IDX_RL_LOW, 8'hff);
        bus(1'b1, IDX_POSTED, 8'h00);
        run(80);
        chk({7'h0, intervalIrq}, 8'h01);
        bus(1'b0, IDX_IV_LOW, 8'h00);
        rd(IDX_IV_HIGH, 8'h01);
        bus(1'b1, IDX_POSTED, 8'h00);
        run(40);
        chk({7'h0, intervalIrq}, 8'h00);
        $display("Interval timer test done");
        bus(1'b1, IDX_FR_LOW, 8'hf8);
        bus(1'b1, IDX_FR_HIGH, 8'hff);
        chk({6'h0, wrapIrq, tickIrq}, 8'h00);
        run(40);
        chk({6'h0, wrapIrq, tickIrq}, 8'h03);
        bus(1'b0, IDX_POSTED, 8'h00);
        chk(q & 8'h03, 8'h03);
        bus(1'b1, IDX_POSTED, 8'h05);
        chk({6'h0, wrapIrq, tickIrq}, 8'h01);
        irqTaken <= 3'b001;
        @(posedge sys_clk);
        irqTaken <= 3'b000;
        @(posedge sys_clk);
        chk({7'h0, tickIrq}, 8'h00);
        bus(1'b1, IDX_POSTED, 8'h00);
        rd(IDX_POSTED, 8'h00);
        $display("Posted interrupt test done");
        bus(1'b1, IDX_CONTROL, 8'h00);
        run(40);
        rd(IDX_FR_LOW, 8'h02);
        chk({5'h0, intervalIrq, wrapIrq, tickIrq}, 8'h00);
        rd(IDX_CONTROL, 8'h00);
        $display("Enable control test done");
        conclude();
    end
endmodule
`default_nettype wire
